/* File: hdl/cfl_charger_supervisor.sv */
// charger supervisor: setting ceilings, droop flag, input and thermal faults, status pin
`default_nettype none
`include "cfl_params.svh"

// Operation
// - droop flag bit 4 reads set while the input hold loop limits current.
// - three-bit droop field selects input hold voltage, eight equal steps.
// - battery above short threshold loads ceiling default; writable until another write.
// - after another register write, ceiling ignores writes until battery below short.
// - float or current code written above ceiling is stored as the ceiling.
// - ceiling holds current limit bits 6:4, float limit 3:0; outputs clamped.
// - current ceiling uses the same eight-step code as current setting.
// - float ceiling n permits float code 100011 plus n.
// - foldback temperature forces lowest current; programmed current returns once cool.
// - shutdown temperature suspends charging, loads fault 101, pulses status pin.
// - thermal suspend freezes the interval timer and state, not the status pulse count; resumes from same state.
// - input below battery plus sleep margin, above minimum, enters sleep.
// - input below minimum while charging stops, pulses, state 11, fault 011.
// - after under-voltage stop, restart once input recovers and retry interval passes.
// - input over-voltage opens blocking switch, suspends, fault 001, state 11, pulse.
// - over-voltage clears at release threshold; charging resumes after input revalidation.
// - after the first switching pulse in charge, no pulses for 30 ms gives fault 100, state 11, pulse.
module cfl_charger_supervisor #(
    parameter int RETRY_CYCLES    = `CFL_RETRY_MS * `CFL_CLK_MHZ * 1000,
    parameter int VALIDATE_CYCLES = `CFL_VALIDATE_MS * `CFL_CLK_MHZ * 1000,
    parameter int NO_PULSE_CYCLES = `CFL_NO_PULSE_MS * `CFL_CLK_MHZ * 1000
) (
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    input  wire logic                       clk_en,
    input  wire cfl_pkg::cfl_sense_type     sense_async,
    input  wire cfl_pkg::cfl_reg_write_type reg_write,
    input  wire logic [7:0]                 reg_rd_addr,
    output var  logic [7:0]                 reg_rd_data,
    output var  cfl_pkg::cfl_setting_type   applied,
    output var  logic                       charge_enable,
    output var  logic                       input_blocking_switch,
    output var  logic                       sleep_mode,
    output var  logic                       current_foldback,
    output var  logic [2:0]                 fault_code,
    output var  logic [1:0]                 state_bits,
    output logic                            stat_out,
    output var  logic                       stat_oe_n
);

    localparam int PULSE_CYCLES_I = `CFL_STAT_PULSE_US * `CFL_CLK_MHZ;
    localparam logic [`CFL_PULSE_W-1:0] PULSE_CYCLES = PULSE_CYCLES_I[`CFL_PULSE_W-1:0];
    localparam logic [`CFL_TIMER_W-1:0] RETRY_LIMIT = RETRY_CYCLES[`CFL_TIMER_W-1:0];
    localparam logic [`CFL_TIMER_W-1:0] VALID_LIMIT = VALIDATE_CYCLES[`CFL_TIMER_W-1:0];
    localparam logic [`CFL_TIMER_W-1:0] NOPLS_LIMIT = NO_PULSE_CYCLES[`CFL_TIMER_W-1:0];

    logic                         rst_meta;
    logic                         rst_n;
    cfl_pkg::cfl_sense_type       sense;
    cfl_pkg::cfl_state_type       state;
    cfl_pkg::cfl_state_type       next_state;
    logic [`CFL_TIMER_W-1:0]      timer;
    logic [`CFL_PULSE_W-1:0]      pulse_count;
    logic [7:0]                   float_reg;
    logic [7:0]                   current_reg;
    logic [2:0]                   hold_reg;
    logic [6:0]                   limit_reg;
    logic                         ceiling_locked;
    logic                         battery_was_above;
    logic                         switch_pulse_prev;
    logic                         pulse_edge;
    logic                         pulses_armed;
    logic                         suspended;
    logic                         thermal_entry;
    logic                         fault_event;
    logic [2:0]                   event_code;
    logic [2:0]                   ceil_current;
    logic [5:0]                   ceil_float;
    logic [5:0]                   write_float;
    logic [2:0]                   write_current;
    logic                         input_in_window;

    // reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // every comparator crosses into clk_sys through one shared synchroniser
    cfl_sync3 #(
        .WIDTH    ($bits(cfl_pkg::cfl_sense_type))
    ) u_sense_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (sense_async),
        .sync_out (sense)
    );

    // ceilings as codes: current is the same step code, float is base plus n
    assign ceil_current = limit_reg[`CFL_CEIL_CC_MSB:`CFL_CEIL_CC_LSB];
    assign ceil_float   = `CFL_FV_CEIL_BASE
                        + {2'h0, limit_reg[`CFL_CEIL_FV_MSB:`CFL_CEIL_FV_LSB]};

    // clamp incoming codes so the stored value does not exceed the ceiling in force at the write
    always_comb
    begin
        write_float   = reg_write.data[`CFL_FV_MSB:`CFL_FV_LSB];
        write_current = reg_write.data[`CFL_CC_MSB:`CFL_CC_LSB];
        if (write_float > ceil_float)
            write_float = ceil_float;
        if (write_current > ceil_current)
            write_current = ceil_current;
    end

    assign pulse_edge      = sense.switch_pulse && !switch_pulse_prev;
    assign input_in_window = !sense.input_below_min && !sense.input_above_ovp;
    assign thermal_entry   = sense.die_shutdown_hot && !suspended;

    // setting registers; host writes stay live during a thermal suspend
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            float_reg   <= `CFL_FLOAT_RESET;
            current_reg <= `CFL_CURRENT_RESET;
            hold_reg    <= `CFL_HOLD_RESET;
        end
        else if (clk_en && reg_write.valid)
        begin
            unique case (reg_write.addr)
                `CFL_ADDR_FLOAT:
                    float_reg <= {write_float, reg_write.data[`CFL_FV_LSB-1:0]};
                `CFL_ADDR_CURRENT:
                    current_reg <= {reg_write.data[7], write_current,
                                    reg_write.data[`CFL_CC_LSB-1:0]};
                `CFL_ADDR_DROOP:
                    hold_reg <= reg_write.data[`CFL_HOLD_MSB:`CFL_HOLD_LSB];
                default:
                    ;
            endcase
        end
    end

    // ceiling register: default reloaded as the battery climbs past short
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            limit_reg         <= `CFL_LIMIT_RESET;
            battery_was_above <= 1'b0;
        end
        else if (clk_en)
        begin
            battery_was_above <= sense.battery_above_short;
            if (sense.battery_above_short && !battery_was_above)
                limit_reg <= `CFL_LIMIT_RESET;
            else if (reg_write.valid && reg_write.addr == `CFL_ADDR_LIMIT && !ceiling_locked)
                limit_reg <= reg_write.data[6:0];
        end
    end

    // lock follows the first write elsewhere; only a low battery unlocks it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ceiling_locked <= 1'b0;
        else if (clk_en)
        begin
            if (!sense.battery_above_short)
                ceiling_locked <= 1'b0;
            else if (reg_write.valid && reg_write.addr != `CFL_ADDR_LIMIT)
                ceiling_locked <= 1'b1;
        end
    end

    // read data is registered; unmapped offsets and reserved bits read zero
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rd_data <= 8'h00;
        else if (clk_en)
        begin
            unique case (reg_rd_addr)
                `CFL_ADDR_FLOAT:   reg_rd_data <= float_reg;
                `CFL_ADDR_CURRENT: reg_rd_data <= current_reg;
                `CFL_ADDR_DROOP:   reg_rd_data <= {3'h0, sense.droop_loop_active,
                                                   1'b0, hold_reg};
                `CFL_ADDR_LIMIT:   reg_rd_data <= {1'b0, limit_reg};
                default:           reg_rd_data <= 8'h00;
            endcase
        end
    end

    // fault sequencing; a thermal suspend holds the machine where it is
    always_comb
    begin
        next_state  = state;
        fault_event = 1'b0;
        event_code  = `CFL_FAULT_NONE;
        if (!sense.die_shutdown_hot)
        begin
            unique case (state)
                cfl_pkg::CFL_VALIDATE:
                begin
                    if (sense.input_above_ovp)
                    begin
                        next_state  = cfl_pkg::CFL_OVP;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_INPUT_OVP;
                    end
                    else if (timer >= VALID_LIMIT)
                        next_state = cfl_pkg::CFL_CHARGE;
                end
                cfl_pkg::CFL_CHARGE:
                begin
                    if (sense.input_above_ovp)
                    begin
                        next_state  = cfl_pkg::CFL_OVP;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_INPUT_OVP;
                    end
                    else if (sense.input_below_min)
                    begin
                        next_state  = cfl_pkg::CFL_UV_RETRY;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_POOR_INPUT;
                    end
                    else if (pulses_armed && timer >= NOPLS_LIMIT)
                    begin
                        next_state  = cfl_pkg::CFL_BAT_OVP;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_BATTERY_OVP;
                    end
                end
                cfl_pkg::CFL_UV_RETRY:
                begin
                    if (sense.input_above_ovp)
                    begin
                        next_state  = cfl_pkg::CFL_OVP;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_INPUT_OVP;
                    end
                    else if (timer >= RETRY_LIMIT && !sense.input_below_min)
                        next_state = cfl_pkg::CFL_VALIDATE;
                end
                cfl_pkg::CFL_OVP:
                begin
                    if (sense.input_below_ovp_release)
                        next_state = cfl_pkg::CFL_VALIDATE;
                end
                cfl_pkg::CFL_BAT_OVP:
                begin
                    if (sense.input_above_ovp)
                    begin
                        next_state  = cfl_pkg::CFL_OVP;
                        fault_event = 1'b1;
                        event_code  = `CFL_FAULT_INPUT_OVP;
                    end
                    else if (pulse_edge)
                        next_state = cfl_pkg::CFL_CHARGE;
                end
                default:
                    next_state = cfl_pkg::CFL_VALIDATE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state <= cfl_pkg::CFL_VALIDATE;
        else if (clk_en)
            state <= next_state;
    end

    // shared interval timer; restarts on each state change, frozen in suspend
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer             <= '0;
            switch_pulse_prev <= 1'b0;
            pulses_armed      <= 1'b0;
        end
        else if (clk_en && !sense.die_shutdown_hot)
        begin
            switch_pulse_prev <= sense.switch_pulse;
            if (next_state != state)
                timer <= '0;
            else if (state == cfl_pkg::CFL_VALIDATE && !input_in_window)
                timer <= '0;
            else if (state == cfl_pkg::CFL_CHARGE && pulse_edge)
                timer <= '0;
            else if (timer != '1)
                timer <= timer + 1'b1;
            // watchdog only arms once the power stage has switched at least once
            if (state != cfl_pkg::CFL_CHARGE || next_state != state)
                pulses_armed <= 1'b0;
            else if (pulse_edge)
                pulses_armed <= 1'b1;
        end
    end

    // fault code and state bits; thermal entry takes precedence over others
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            suspended  <= 1'b0;
            fault_code <= `CFL_FAULT_NONE;
            state_bits <= `CFL_STATE_READY;
        end
        else if (clk_en)
        begin
            suspended <= sense.die_shutdown_hot;
            if (thermal_entry)
                fault_code <= `CFL_FAULT_THERMAL;
            else if (fault_event)
                fault_code <= event_code;
            else if (next_state == cfl_pkg::CFL_CHARGE && state == cfl_pkg::CFL_VALIDATE)
                fault_code <= `CFL_FAULT_NONE;
            if (next_state == cfl_pkg::CFL_OVP || next_state == cfl_pkg::CFL_UV_RETRY
                || next_state == cfl_pkg::CFL_BAT_OVP)
                state_bits <= `CFL_STATE_FAULT;
            else if (next_state == cfl_pkg::CFL_CHARGE)
                state_bits <= `CFL_STATE_CHARGING;
            else
                state_bits <= `CFL_STATE_READY;
        end
    end

    // status pin: one fixed-width low pulse per fault entry, then released
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pulse_count <= '0;
        else if (clk_en)
        begin
            if (fault_event || thermal_entry)
                pulse_count <= PULSE_CYCLES;
            else if (pulse_count != '0)
                pulse_count <= pulse_count - 1'b1;
        end
    end

    assign stat_out = 1'b0; // open drain: only ever pulls low

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stat_oe_n <= 1'b1;
        else if (clk_en)
            stat_oe_n <= !(fault_event || thermal_entry || pulse_count > 1);
    end

    // power stage controls; settings are clamped again in case the ceiling dropped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            applied               <= '0;
            charge_enable         <= 1'b0;
            input_blocking_switch <= 1'b0;
            sleep_mode            <= 1'b0;
            current_foldback      <= 1'b0;
        end
        else if (clk_en)
        begin
            sleep_mode <= sense.input_below_sleep && !sense.input_below_min;
            current_foldback <= sense.die_foldback_hot;
            input_blocking_switch <= next_state != cfl_pkg::CFL_OVP;
            charge_enable <= next_state == cfl_pkg::CFL_CHARGE
                          && !sense.die_shutdown_hot
                          && !(sense.input_below_sleep && !sense.input_below_min);
            applied.input_hold_voltage <= hold_reg;
            if (float_reg[`CFL_FV_MSB:`CFL_FV_LSB] > ceil_float)
                applied.float_voltage_code <= ceil_float;
            else
                applied.float_voltage_code <= float_reg[`CFL_FV_MSB:`CFL_FV_LSB];
            if (sense.die_foldback_hot)
                applied.charge_current_code <= `CFL_CC_FOLDBACK;
            else if (current_reg[`CFL_CC_MSB:`CFL_CC_LSB] > ceil_current)
                applied.charge_current_code <= ceil_current;
            else
                applied.charge_current_code <= current_reg[`CFL_CC_MSB:`CFL_CC_LSB];
        end
    end

endmodule : cfl_charger_supervisor

`default_nettype wire

/* File: hdl/cfl_params.svh */
// named offsets, field positions, reset values, codes and timings of the charger supervisor
`ifndef CFL_PARAMS_SVH
`define CFL_PARAMS_SVH

// register offsets
`define CFL_ADDR_FLOAT          8'h02
`define CFL_ADDR_CURRENT        8'h04
`define CFL_ADDR_DROOP          8'h05
`define CFL_ADDR_LIMIT          8'h06

// field positions
`define CFL_FV_MSB              7
`define CFL_FV_LSB              2
`define CFL_CC_MSB              6
`define CFL_CC_LSB              4
`define CFL_DROOP_FLAG_BIT      4
`define CFL_HOLD_MSB            2
`define CFL_HOLD_LSB            0
`define CFL_CEIL_CC_MSB         6
`define CFL_CEIL_CC_LSB         4
`define CFL_CEIL_FV_MSB         3
`define CFL_CEIL_FV_LSB         0

// reset values
`define CFL_FLOAT_RESET         8'h28
`define CFL_CURRENT_RESET       8'h00
`define CFL_HOLD_RESET          3'h0
`define CFL_LIMIT_RESET         7'h7f

// float ceiling code n permits a float code of base plus n
`define CFL_FV_CEIL_BASE        6'h23
// reduced current under die foldback is the lowest current step
`define CFL_CC_FOLDBACK         3'h0

// fault codes
`define CFL_FAULT_NONE          3'h0
`define CFL_FAULT_INPUT_OVP     3'h1
`define CFL_FAULT_POOR_INPUT    3'h3
`define CFL_FAULT_BATTERY_OVP   3'h4
`define CFL_FAULT_THERMAL       3'h5

// charge state bits
`define CFL_STATE_READY         2'h0
`define CFL_STATE_CHARGING      2'h1
`define CFL_STATE_FAULT         2'h3

// timing
`define CFL_CLK_MHZ             25
`define CFL_STAT_PULSE_US       128
`define CFL_RETRY_MS            2000
`define CFL_VALIDATE_MS         30
`define CFL_NO_PULSE_MS         30
`define CFL_TIMER_W             26
`define CFL_PULSE_W             12

`endif

/* File: hdl/cfl_pkg.sv */
// types shared by the charger supervisor files
`default_nettype none

package cfl_pkg;

    // comparator and power stage indications, all asynchronous to clk_sys
    typedef struct packed {
        logic die_foldback_hot;
        logic die_shutdown_hot;
        logic input_below_sleep;
        logic input_below_min;
        logic input_above_ovp;
        logic input_below_ovp_release;
        logic battery_above_short;
        logic droop_loop_active;
        logic switch_pulse;
    } cfl_sense_type;

    // one register write from the serial interface
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } cfl_reg_write_type;

    // settings handed to the regulation loops
    typedef struct packed {
        logic [5:0] float_voltage_code;
        logic [2:0] charge_current_code;
        logic [2:0] input_hold_voltage;
    } cfl_setting_type;

    typedef enum logic [2:0] {
        CFL_VALIDATE = 3'h0,
        CFL_CHARGE   = 3'h1,
        CFL_UV_RETRY = 3'h3,
        CFL_OVP      = 3'h2,
        CFL_BAT_OVP  = 3'h6
    } cfl_state_type;

endpackage : cfl_pkg

`default_nettype wire

/* File: hdl/cfl_sync3.sv */
// three-flop input synchroniser that accepts a change once stages two and three agree
`default_nettype none

module cfl_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // stage1 feeds stage2 only; metastability never reaches the compare
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2[i] == stage3[i])
                    sync_out[i] <= stage3[i];
            end
        end
    end

endmodule : cfl_sync3

`default_nettype wire

/* File: sim/cfl_stage_model.sv */
// comparator and power stage stand-in driving the sense inputs
`default_nettype none
module cfl_stage_model (
    input  wire logic                   clk_sys,
    input  wire cfl_pkg::cfl_sense_type levels,
    input  wire logic                   switching,
    output var  cfl_pkg::cfl_sense_type sense_async
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph = 2'h0; // one switching pulse every four cycles
    always @(negedge clk_sys) ph <= ph + 2'h1;
    // pulses stop dead when the stage idles, as a stalled loop does
    always_comb
    begin
        sense_async = levels;
        sense_async.switch_pulse = switching & ph[1];
    end
endmodule : cfl_stage_model
`default_nettype wire

/* File: sim/cfl_sup_assertions.sv */
// port-level checks of the charger supervisor
`default_nettype none
module cfl_sup_assertions (
    input wire logic                     clk_sys,
    input wire logic                     arst_n,
    input wire cfl_pkg::cfl_setting_type applied,
    input wire logic                     charge_enable,
    input wire logic                     input_blocking_switch,
    input wire logic                     sleep_mode,
    input wire logic                     current_foldback,
    input wire logic [2:0]               fault_code,
    input wire logic [1:0]               state_bits,
    input wire logic                     stat_oe_n
);
    logic [11:0] low_cnt; // low cycles of the status pin so far
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a counter, since a repetition of thousands would choke the tools
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n) low_cnt <= 12'h000;
        else low_cnt <= stat_oe_n ? 12'h000 : low_cnt + 12'h001;
    chk_pulse_length: assert property ($rose(stat_oe_n) |-> low_cnt == 12'hc80)
        else $error("status pulse length wrong");
    chk_entry_pulse: assert property ($changed(fault_code) && fault_code != 3'h0 |-> !stat_oe_n)
        else $error("fault entered without status pulse");
    chk_fault_state: assert property ($changed(fault_code) && fault_code inside {3'h1, 3'h3, 3'h4}
        |-> state_bits == 2'h3)
        else $error("fault state bits wrong");
    chk_ovp_switch: assert property ($changed(fault_code) && fault_code == 3'h1
        |-> !input_blocking_switch && !charge_enable)
        else $error("switch closed in over-voltage");
    chk_thermal_stop: assert property ($changed(fault_code) && fault_code == 3'h5 |-> !charge_enable)
        else $error("charging during thermal fault");
    chk_fold_current: assert property (current_foldback && $past(current_foldback)
        |-> applied.charge_current_code == 3'h0)
        else $error("foldback current not reduced");
    chk_float_limit: assert property (applied.float_voltage_code <= 6'h32)
        else $error("float code above top ceiling");
    chk_sleep_blocks: assert property (sleep_mode |-> !charge_enable)
        else $error("charging while asleep");
endmodule : cfl_sup_assertions
bind cfl_charger_supervisor cfl_sup_assertions i_chk (.clk_sys, .arst_n, .applied, .charge_enable,
    .input_blocking_switch, .sleep_mode, .current_foldback, .fault_code, .state_bits, .stat_oe_n);
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench of the charger supervisor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, arst_n = 1'b0, sw = 1'b0, ce, sw_on, slp, fold, so, soe;
    logic [7:0] rd_addr = 8'h00, rd_data;
    logic [2:0] fc;
    logic [1:0] st;
    cfl_pkg::cfl_sense_type lv = '0, sense;
    cfl_pkg::cfl_reg_write_type wr = '0;
    cfl_pkg::cfl_setting_type ap;
    int n_fail = 0, checks = 0, m_fv = 'h28, m_cc = 0, m_hold = 0, m_lim = 'h7f, m_lock = 0, d, i;
    always #20 clk_sys = ~clk_sys;
    cfl_stage_model i_cfl_stage_model (.clk_sys, .levels(lv), .switching(sw), .sense_async(sense));
    cfl_charger_supervisor #(.RETRY_CYCLES(40), .VALIDATE_CYCLES(20), .NO_PULSE_CYCLES(30))
    i_cfl_charger_supervisor (.clk_sys, .arst_n, .clk_en(1'b1), .sense_async(sense),
        .reg_write(wr), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data), .applied(ap),
        .charge_enable(ce), .input_blocking_switch(sw_on), .sleep_mode(slp),
        .current_foldback(fold), .fault_code(fc), .state_bits(st), .stat_out(so), .stat_oe_n(soe));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // model update first, then one write cycle and a spare cycle
    task automatic write(input logic [7:0] a, input logic [7:0] v);
        int f, c;
        f = v / 4 > 35 + m_lim % 16 ? 35 + m_lim % 16 : v / 4;
        c = v / 16 % 8 > m_lim / 16 ? m_lim / 16 : v / 16 % 8;
        if (a == 8'h02) m_fv = f * 4 + v % 4;
        if (a == 8'h04) m_cc = (v & 8'h8f) + c * 16;
        if (a == 8'h05) m_hold = v % 8;
        if (a == 8'h06 && m_lock == 0) m_lim = v % 128;
        if (a != 8'h06 && lv.battery_above_short) m_lock = 1;
        wr <= '{1'b1, a, v};
        tick(1);
        wr.valid <= 1'b0;
        tick(1);
    endtask : write
    function automatic int mread(input int a);
        case (a)
            2: return m_fv;
            4: return m_cc;
            5: return m_hold + 16 * int'(lv.droop_loop_active);
            6: return m_lim;
            default: return 0;
        endcase
    endfunction : mread
    // reads 02 to 07, unmapped ones too, then the applied settings
    task automatic check_all;
        for (d = 2; d < 8; d++)
        begin
            rd_addr <= 8'(d);
            tick(1);
            cmp(rd_data, 8'(mread(d)));
        end
        i = 35 + m_lim % 16; // ceiling caps older codes too
        cmp({2'h0, ap.float_voltage_code}, 8'(m_fv / 4 > i ? i : m_fv / 4));
        cmp({5'h0, ap.charge_current_code}, 8'(m_cc / 16 % 8));
        cmp({5'h0, ap.input_hold_voltage}, 8'(m_hold));
    endtask : check_all
    task automatic wait_fault(input logic [2:0] e);
        for (i = 0; i < 300 && fc !== e; i++) tick(1);
        if (i == 300) n_fail++;
        if (i == 300) conclude();
    endtask : wait_fault
    initial
    begin
        void'($urandom(97));
        tick(4);
        arst_n <= 1'b1;
        tick(6);
        check_all();
        lv.battery_above_short <= 1'b1;
        tick(6);
        for (int k = 0; k < 6; k++)
        begin
            write(8'h06, 8'($urandom));
            write(8'h04, 8'($urandom));
            write(8'h02, 8'($urandom));
            write(8'h05, 8'($urandom));
            check_all();
        end
        lv.battery_above_short <= 1'b0;
        lv.droop_loop_active <= 1'b1;
        tick(6);
        m_lock = 0;
        write(8'h06, 8'($urandom));
        write(8'h04, 8'h7f);
        check_all();
        lv.battery_above_short <= 1'b1;
        tick(6);
        m_lim = 'h7f;
        check_all();
        $display("register tests done");
        cmp({6'h0, st}, 8'h01);
        sw <= 1'b1;
        tick(20);
        sw <= 1'b0;
        wait_fault(3'h4);
        tick(3300);
        sw <= 1'b1;
        tick(10);
        cmp({6'h0, st}, 8'h01);
        lv.input_above_ovp <= 1'b1;
        wait_fault(3'h1);
        cmp({6'h0, soe, sw_on}, 8'h00);
        tick(3300);
        lv.input_above_ovp <= 1'b0;
        lv.input_below_ovp_release <= 1'b1;
        wait_fault(3'h0);
        lv.input_below_ovp_release <= 1'b0;
        lv.input_below_min <= 1'b1;
        wait_fault(3'h3);
        tick(3300);
        lv.input_below_min <= 1'b0;
        wait_fault(3'h0);
        lv.die_shutdown_hot <= 1'b1;
        wait_fault(3'h5);
        tick(3300);
        cmp({5'h0, fc}, 8'h05);
        lv.die_shutdown_hot <= 1'b0;
        tick(10);
        cmp({6'h0, st}, 8'h01);
        lv.die_foldback_hot <= 1'b1;
        tick(8);
        cmp({4'h0, fold, ap.charge_current_code}, 8'h08);
        lv.die_foldback_hot <= 1'b0;
        lv.input_below_sleep <= 1'b1;
        tick(8);
        cmp({5'h0, ap.charge_current_code}, 8'(m_cc / 16 % 8));
        cmp({5'h0, so, slp, ce}, 8'h02);
        $display("fault tests done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
